// ===== hdl/synoc_top.sv
// Top level: mode, divider source, output dividers, stop and lock logic
//
// The strobed register port and the register offsets were decided locally.
`timescale 1ns/10ps
module synoc_top #(
    parameter int LOCK_CYC = synoc_pkg::LOCK_CYC
) (
    input  wire logic        clock,
    input  wire logic        reset,
    input  wire logic        master_reset_n,
    input  wire logic        pll_select,
    input  wire logic        test_enable,
    input  wire logic        ref_select,
    input  wire logic        config_source_select,
    input  wire logic        xtal_ref,
    input  wire logic        ext_ref,
    input  wire logic        vco_clk,
    input  wire logic        pfd_match,
    input  wire logic [9:0]  feedback_pins,
    input  wire logic [2:0]  output_divider,
    input  wire logic        secondary_ratio,
    input  wire logic        predivider_pin,
    input  wire logic        output_halt_a_n,
    input  wire logic        output_halt_b_n,
    input  wire logic [3:0]  reg_addr,
    input  wire logic [7:0]  reg_wdata,
    input  wire logic        reg_write,
    input  wire logic        reg_read,
    output logic      [7:0]  reg_rdata,
    output logic             irq,
    output logic             primary_out,
    output logic             secondary_out,
    output logic             lock_out,
    output logic             ref_to_pfd,
    output logic             fb_to_pfd,
    output logic             test_mode
);

    // ------------------------------------------------------------
    // Synchronisers for pin inputs
    // ------------------------------------------------------------
    logic [4:0] pin_s1_r;
    logic [4:0] pin_s2_r;
    logic       mres_s1_r;
    logic       mres_s2_r;
    logic       mres_d_r;

    always_ff @(posedge clock) begin
        if (reset) begin
            pin_s1_r  <= 5'h15;
            pin_s2_r  <= 5'h15;
            mres_s1_r <= 1'b0;
            mres_s2_r <= 1'b0;
            mres_d_r  <= 1'b0;
        end else begin
            pin_s1_r  <= {pll_select, test_enable, ref_select, config_source_select, pfd_match};
            pin_s2_r  <= pin_s1_r;
            mres_s1_r <= master_reset_n;
            mres_s2_r <= mres_s1_r;
            mres_d_r  <= mres_s2_r;
        end
    end

    logic pll_on;
    logic src_reg;
    logic match_s;
    logic mres_rise;

    assign pll_on    = pin_s2_r[4];
    assign src_reg   = pin_s2_r[1];
    assign match_s   = pin_s2_r[0];
    assign mres_rise = mres_s2_r & ~mres_d_r;

    assign test_mode = pin_s2_r[3];

    // ------------------------------------------------------------
    // Configuration registers
    // ------------------------------------------------------------
    synoc_pkg::synoc_cfg_t pin_cfg;
    synoc_pkg::synoc_cfg_t reg_cfg_r;
    synoc_pkg::synoc_cfg_t div_cfg_r;
    synoc_pkg::synoc_cfg_t act_cfg;
    logic [2:0]            status_r;
    logic [2:0]            mask_r;
    logic [2:0]            events;

    assign pin_cfg = '{feedback_pins, output_divider, secondary_ratio, predivider_pin};

    logic wr_cmd;
    assign wr_cmd = reg_write && (reg_addr == synoc_pkg::REG_CMD);

    // low picks pins, high picks registers
    assign act_cfg = src_reg ? div_cfg_r : pin_cfg;

    always_ff @(posedge clock) begin
        if (reset) begin
            reg_cfg_r <= synoc_pkg::CFG_RST;
        end else if (reg_write && reg_addr == synoc_pkg::REG_CFG_LO) begin
            reg_cfg_r.feedback[7:0] <= reg_wdata;
        end else if (reg_write && reg_addr == synoc_pkg::REG_CFG_HI) begin
            reg_cfg_r <= '{{reg_wdata[7:6], reg_cfg_r.feedback[7:0]}, reg_wdata[5:3],
                           reg_wdata[2], reg_wdata[1]};
        end else if (wr_cmd && reg_wdata[3:0] == synoc_pkg::CMD_GET) begin
            reg_cfg_r <= act_cfg;
        end
    end

    // startup load from pins on master reset release
    always_ff @(posedge clock) begin
        if (reset) begin
            div_cfg_r <= synoc_pkg::CFG_RST;
        end else if (mres_rise) begin
            div_cfg_r <= pin_cfg;
        end else if (!src_reg) begin
            div_cfg_r <= pin_cfg;
        end else if (wr_cmd) begin
            case (reg_wdata[3:0])
                synoc_pkg::CMD_INC:  div_cfg_r.feedback <= div_cfg_r.feedback + 10'h001;
                synoc_pkg::CMD_DEC:  div_cfg_r.feedback <= div_cfg_r.feedback - 10'h001;
                synoc_pkg::CMD_LOAD: div_cfg_r <= reg_cfg_r;
                default:             div_cfg_r <= div_cfg_r;
            endcase
        end
    end

    // ------------------------------------------------------------
    // Reference select and predivider
    // ------------------------------------------------------------
    logic ref_clk;
    logic [1:0] pre_cnt_r;
    logic pre_out_r;

    assign ref_clk = pin_s2_r[2] ? xtal_ref : ext_ref;

    always_ff @(posedge ref_clk or negedge master_reset_n) begin
        if (!master_reset_n) begin
            pre_cnt_r <= 2'h0;
            pre_out_r <= 1'b0;
        end else begin
            pre_cnt_r <= pre_cnt_r + 2'h1;
            pre_out_r <= act_cfg.predivider ? pre_cnt_r[1] : pre_cnt_r[0];
        end
    end
    // divided reference to the phase detector
    assign ref_to_pfd = pre_out_r;

    // Feedback divider to phase detector
    logic [9:0] fb_cnt_r;
    logic       fb_out_r;
    always_ff @(posedge vco_clk or negedge master_reset_n) begin
        if (!master_reset_n) begin
            fb_cnt_r <= 10'h000;
            fb_out_r <= 1'b0;
        end else if (fb_cnt_r >= act_cfg.feedback - 10'h001) begin
            fb_cnt_r <= 10'h000;
            fb_out_r <= 1'b1;
        end else begin
            fb_cnt_r <= fb_cnt_r + 10'h001;
            fb_out_r <= (fb_cnt_r < (act_cfg.feedback >> 1)) ? 1'b1 : 1'b0;
        end
    end
    assign fb_to_pfd = fb_out_r;

    // ------------------------------------------------------------
    // Output dividers
    // ------------------------------------------------------------
    function automatic logic [6:0] od_ratio(input logic [2:0] code);
        case (code)
            3'h0:    od_ratio = synoc_pkg::OD_R2;
            3'h1:    od_ratio = synoc_pkg::OD_R4;
            3'h2:    od_ratio = synoc_pkg::OD_R8;
            3'h3:    od_ratio = synoc_pkg::OD_R16;
            3'h4:    od_ratio = synoc_pkg::OD_R32;
            default: od_ratio = synoc_pkg::OD_R64;
        endcase
    endfunction

    logic       src_clk;
    logic [5:0] od_cnt_r;
    logic       prim_r;
    logic       sec_r;
    logic [6:0] ratio;

    // bypass routes reference around the PLL
    assign src_clk = pll_on ? vco_clk : ref_clk;
    assign ratio   = od_ratio(act_cfg.output_divider);

    always_ff @(posedge src_clk or negedge master_reset_n) begin
        if (!master_reset_n) begin
            od_cnt_r <= 6'h00;
            prim_r   <= 1'b0;
        end else if (od_cnt_r >= 6'(ratio[6:1] - 7'h01)) begin
            od_cnt_r <= 6'h00;
            prim_r   <= ~prim_r;
        end else begin
            od_cnt_r <= od_cnt_r + 6'h01;
        end
    end

    // secondary at same or half frequency
    always_ff @(posedge prim_r or negedge master_reset_n) begin
        if (!master_reset_n) begin
            sec_r <= 1'b0;
        end else begin
            sec_r <= ~sec_r;
        end
    end

    logic sec_src;
    assign sec_src = act_cfg.secondary_ratio ? sec_r : prim_r;

    // outputs forced low in master reset
    synoc_out_gate u_gate_a (
        .out_clk        (prim_r),
        .master_reset_n (master_reset_n),
        .output_halt_n  (output_halt_a_n),
        .clk_in         (prim_r),
        .clk_out        (primary_out)
    );

    synoc_out_gate u_gate_b (
        .out_clk        (sec_src),
        .master_reset_n (master_reset_n),
        .output_halt_n  (output_halt_b_n),
        .clk_in         (sec_src),
        .clk_out        (secondary_out)
    );

    // ------------------------------------------------------------
    // Lock detector
    // ------------------------------------------------------------
    synoc_pkg::synoc_lock_t lock_st_r;
    logic [15:0]            lock_cnt_r;
    logic                   locked;

    // acquire after release, lock after lock time
    always_ff @(posedge clock) begin
        if (reset || !mres_s2_r || mres_rise) begin
            lock_st_r  <= synoc_pkg::ST_RESET;
            lock_cnt_r <= 16'h0000;
        end else begin
            case (lock_st_r)
                synoc_pkg::ST_RESET: begin
                    lock_st_r  <= synoc_pkg::ST_ACQUIRE;
                    lock_cnt_r <= 16'h0000;
                end
                synoc_pkg::ST_ACQUIRE: begin
                    if (!match_s) begin
                        lock_cnt_r <= 16'h0000;
                    end else if (lock_cnt_r >= 16'(LOCK_CYC - 1)) begin
                        lock_st_r <= synoc_pkg::ST_LOCKED;
                    end else begin
                        lock_cnt_r <= lock_cnt_r + 16'h0001;
                    end
                end
                synoc_pkg::ST_LOCKED: begin
                    if (!match_s) begin
                        lock_st_r  <= synoc_pkg::ST_ACQUIRE;
                        lock_cnt_r <= 16'h0000;
                    end
                end
                default: lock_st_r <= synoc_pkg::ST_RESET;
            endcase
        end
    end

    // lock high on phase and frequency match
    assign locked = (lock_st_r == synoc_pkg::ST_LOCKED);
    // lock pin carries test signal in bypass
    assign lock_out = pll_on ? locked : ref_to_pfd;

    // ------------------------------------------------------------
    // Events, interrupt and read port
    // ------------------------------------------------------------
    logic locked_d_r;
    always_ff @(posedge clock) begin
        if (reset) begin
            locked_d_r <= 1'b0;
        end else begin
            locked_d_r <= locked;
        end
    end

    assign events = {mres_rise, locked_d_r & ~locked, locked & ~locked_d_r};

    always_ff @(posedge clock) begin
        if (reset) begin
            status_r <= 3'h0;
        end else if (reg_write && reg_addr == synoc_pkg::REG_STATUS) begin
            status_r <= (status_r & ~reg_wdata[2:0]) | events;
        end else begin
            status_r <= status_r | events;
        end
    end

    always_ff @(posedge clock) begin
        if (reset) begin
            mask_r <= 3'h0;
        end else if (reg_write && reg_addr == synoc_pkg::REG_MASK) begin
            mask_r <= reg_wdata[2:0];
        end
    end

    assign irq = |(status_r & mask_r);

    always_ff @(posedge clock) begin
        if (reset) begin
            reg_rdata <= 8'h00;
        end else if (reg_read) begin
            case (reg_addr)
                synoc_pkg::REG_CFG_LO: reg_rdata <= reg_cfg_r.feedback[7:0];
                synoc_pkg::REG_CFG_HI: reg_rdata <= {reg_cfg_r.feedback[9:8],
                                                     reg_cfg_r.output_divider,
                                                     reg_cfg_r.secondary_ratio,
                                                     reg_cfg_r.predivider, locked};
                synoc_pkg::REG_ID:     reg_rdata <= synoc_pkg::ID_VALUE;
                synoc_pkg::REG_STATUS: reg_rdata <= {5'h00, status_r};
                synoc_pkg::REG_MASK:   reg_rdata <= {5'h00, mask_r};
                default:               reg_rdata <= 8'h00;
            endcase
        end else begin
            reg_rdata <= 8'h00;
        end
    end

endmodule

// ===== hdl/synoc_pkg.sv
// Package: constants and carriers for the synthesizer output mode control
package synoc_pkg;

    // Divider field widths
    localparam int FB_W  = 10;
    localparam int OD_W  = 3;
    localparam int CNT_W = 12;

    // Startup defaults of the parallel pins
    localparam logic [9:0] FB_RST     = 10'h1F4;
    localparam logic [2:0] OD_RST     = 3'h2;
    localparam logic       SR_RST     = 1'h0;
    localparam logic       PRE_RST    = 1'h1;

    // Output divider code table: code to ratio
    localparam logic [6:0] OD_R2  = 7'h02;
    localparam logic [6:0] OD_R4  = 7'h04;
    localparam logic [6:0] OD_R8  = 7'h08;
    localparam logic [6:0] OD_R16 = 7'h10;
    localparam logic [6:0] OD_R32 = 7'h20;
    localparam logic [6:0] OD_R64 = 7'h40;

    // Lock timing
    localparam int LOCK_TIME_US  = 10;
    localparam int CLK_MHZ       = 125;
    localparam int LOCK_CYC      = LOCK_TIME_US * CLK_MHZ;
    localparam int MATCH_CYC     = 4;

    // Status and mask bit positions
    localparam int EV_LOCK   = 0;
    localparam int EV_UNLOCK = 1;
    localparam int EV_LOAD   = 2;

    // Register indices
    localparam logic [3:0] REG_CFG_LO  = 4'h0;
    localparam logic [3:0] REG_CFG_HI  = 4'h1;
    localparam logic [3:0] REG_CMD     = 4'hF;
    localparam logic [3:0] REG_ID      = 4'h8;
    localparam logic [3:0] REG_STATUS  = 4'h2;
    localparam logic [3:0] REG_MASK    = 4'h3;

    // Command codes
    localparam logic [3:0] CMD_INC  = 4'h1;
    localparam logic [3:0] CMD_DEC  = 4'h2;
    localparam logic [3:0] CMD_LOAD = 4'h4;
    localparam logic [3:0] CMD_GET  = 4'h8;

    // Arbitrary identification value
    localparam logic [7:0] ID_VALUE = 8'hA5;

    typedef struct packed {
        logic [9:0] feedback;
        logic [2:0] output_divider;
        logic       secondary_ratio;
        logic       predivider;
    } synoc_cfg_t;

    localparam synoc_cfg_t CFG_RST = '{FB_RST, OD_RST, SR_RST, PRE_RST};

    typedef enum logic [1:0] {
        ST_RESET   = 2'b00,
        ST_ACQUIRE = 2'b01,
        ST_LOCKED  = 2'b10
    } synoc_lock_t;

endpackage

// ===== hdl/synoc_out_gate.sv
// Glitch free stop gate for one output clock
`timescale 1ns/10ps
module synoc_out_gate (
    input  wire logic out_clk,
    input  wire logic master_reset_n,
    input  wire logic output_halt_n,
    input  wire logic clk_in,
    output logic      clk_out
);

    logic sync1_r;
    logic sync2_r;

    // Stop input resynchronised on falling edge of the output clock
    always_ff @(negedge out_clk or negedge master_reset_n) begin
        if (!master_reset_n) begin
            sync1_r <= 1'b0;
            sync2_r <= 1'b0;
        end else begin
            sync1_r <= output_halt_n;
            sync2_r <= sync1_r;
        end
    end

    // Stop changes the enable only while clock is low, so no runt; master reset clears it at once
    assign clk_out = clk_in & sync2_r & master_reset_n;

endmodule

// ===== test/synoc_top_sva.sv
// Checker: port level properties of the synthesizer control
`timescale 1ns/10ps
module synoc_top_chk #(
    parameter int LOCK_CYC = 8
) (
    input  wire logic       clock,
    input  wire logic       reset,
    input  wire logic       master_reset_n,
    input  wire logic       pll_select,
    input  wire logic       test_enable,
    input  wire logic       pfd_match,
    input  wire logic       output_halt_a_n,
    input  wire logic [3:0] reg_addr,
    input  wire logic       reg_read,
    input  wire logic [7:0] reg_rdata,
    input  wire logic       primary_out,
    input  wire logic       secondary_out,
    input  wire logic       lock_out,
    input  wire logic       test_mode
);
    localparam int HALT_WAIT = 200;
    int   match_r;
    int   pll_r;
    int   halt_r;
    logic pll_ok;

    default clocking @(posedge clock); endclocking
    default disable iff (reset);

    // ----------------
    // Helper counters
    // ----------------
    always_ff @(posedge clock) match_r <= (reset || !pfd_match) ? 0 : match_r + 1;
    always_ff @(posedge clock) pll_r <= (reset || !pll_select) ? 0 : pll_r + 1;
    always_ff @(posedge clock) halt_r <= (reset || output_halt_a_n) ? 0 : halt_r + 1;
    assign pll_ok = pll_r > 4;

    // ----------------
    // Properties
    // ----------------
    sequence s_mres_held;
        (pll_ok && !master_reset_n) [*5];
    endsequence
    sequence s_match_lost;
        (pll_ok && !pfd_match) [*5];
    endsequence
    sequence s_read_id;
        reg_read && reg_addr == synoc_pkg::REG_ID;
    endsequence

    AST_MRES_OUT_LOW: assert property (!master_reset_n |-> !primary_out && !secondary_out)
        else $error("outputs not low in master reset");
    AST_LOCK_IN_MRES: assert property (s_mres_held |-> !lock_out)
        else $error("lock high in master reset");
    AST_LOCK_RISE: assert property (pll_ok && $rose(lock_out) |-> match_r >= LOCK_CYC)
        else $error("lock rose before match time");
    AST_LOCK_LOST: assert property (s_match_lost |-> !lock_out)
        else $error("lock held without match");
    AST_HALT: assert property (halt_r > HALT_WAIT |-> !primary_out)
        else $error("primary runs while halted");
    AST_TEST: assert property ($stable(test_enable) [*4] |-> test_mode == test_enable)
        else $error("test mode does not follow select");
    AST_RD_IDLE: assert property (!$past(reg_read) |-> reg_rdata == 8'h00)
        else $error("read data outside read slot");
    AST_RD_ID: assert property (s_read_id |=> reg_rdata == synoc_pkg::ID_VALUE)
        else $error("wrong identification value");
endmodule

bind synoc_top synoc_top_chk #(.LOCK_CYC(LOCK_CYC)) u_chk (
    .clock(clock), .reset(reset), .master_reset_n(master_reset_n),
    .pll_select(pll_select), .test_enable(test_enable), .pfd_match(pfd_match),
    .output_halt_a_n(output_halt_a_n), .reg_addr(reg_addr), .reg_read(reg_read),
    .reg_rdata(reg_rdata), .primary_out(primary_out), .secondary_out(secondary_out),
    .lock_out(lock_out), .test_mode(test_mode)
);

// ===== test/synoc_board.sv
// Board model: reference and oscillator clocks, downstream edge counters
`timescale 1ns/10ps
module synoc_board (
    input  wire logic        primary_out,
    input  wire logic        secondary_out,
    output logic             xtal_ref,
    output logic             ext_ref,
    output logic             vco_clk,
    output logic      [15:0] prim_cnt,
    output logic      [15:0] sec_cnt
);
    initial begin
        xtal_ref = 1'h0;
        forever #20 xtal_ref = ~xtal_ref;
    end
    initial begin
        ext_ref = 1'h0;
        forever #28 ext_ref = ~ext_ref;
    end
    initial begin
        vco_clk = 1'h0;
        forever #2.5 vco_clk = ~vco_clk;
    end
    initial begin
        prim_cnt = 16'h0000;
        sec_cnt  = 16'h0000;
    end
    // Downstream chip counts rising edges
    always @(posedge primary_out) prim_cnt <= prim_cnt + 16'h0001;
    always @(posedge secondary_out) sec_cnt <= sec_cnt + 16'h0001;
endmodule

// ===== test/synth_output_mode_control_tb.sv
// Testbench: divider rows, then reference, stop, load, register, reset, lock and test mode
`timescale 1ns/10ps
module synth_output_mode_control_tb;
    localparam int LOCK = 8;
    typedef struct packed {
        logic       pll;
        logic [2:0] od;
        logic       sr;
        logic       half;
    } synoc_row_t;
    localparam synoc_row_t ROWS [5] = '{'{1'h1, 3'h0, 1'h0, 1'h0}, '{1'h1, 3'h1, 1'h1, 1'h1},
        '{1'h0, 3'h0, 1'h0, 1'h0}, '{1'h0, 3'h1, 1'h1, 1'h1}, '{1'h1, 3'h2, 1'h1, 1'h1}};
    logic        clock, reset, master_reset_n, pll_select, test_enable, ref_select;
    logic        config_source_select, xtal_ref, ext_ref, vco_clk, pfd_match;
    logic        secondary_ratio, predivider_pin, output_halt_a_n, output_halt_b_n;
    logic        reg_write, reg_read, irq, primary_out, secondary_out, lock_out, test_mode;
    logic [9:0]  feedback_pins;
    logic [2:0]  output_divider;
    logic [3:0]  reg_addr;
    logic [7:0]  reg_wdata, reg_rdata, rd_v;
    logic [15:0] prim_cnt, sec_cnt, dp, ds, ex, a0;
    logic        ref_pfd, fb_pfd;
    logic [15:0] ref_n, fb_n;
    int          fails, num_checks;

    synoc_top #(.LOCK_CYC(LOCK)) DUT (
        .clock(clock), .reset(reset), .master_reset_n(master_reset_n),
        .pll_select(pll_select), .test_enable(test_enable), .ref_select(ref_select),
        .config_source_select(config_source_select), .xtal_ref(xtal_ref), .ext_ref(ext_ref),
        .vco_clk(vco_clk), .pfd_match(pfd_match), .feedback_pins(feedback_pins),
        .output_divider(output_divider), .secondary_ratio(secondary_ratio),
        .predivider_pin(predivider_pin), .output_halt_a_n(output_halt_a_n),
        .output_halt_b_n(output_halt_b_n), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
        .reg_write(reg_write), .reg_read(reg_read), .reg_rdata(reg_rdata), .irq(irq),
        .primary_out(primary_out), .secondary_out(secondary_out), .lock_out(lock_out),
        .ref_to_pfd(ref_pfd), .fb_to_pfd(fb_pfd), .test_mode(test_mode)
    );
    synoc_board BOARD (
        .primary_out(primary_out), .secondary_out(secondary_out), .xtal_ref(xtal_ref),
        .ext_ref(ext_ref), .vco_clk(vco_clk), .prim_cnt(prim_cnt), .sec_cnt(sec_cnt)
    );
    // Edge counters on the phase detector inputs
    always @(posedge ref_pfd) ref_n <= ref_n + 16'h0001;
    always @(posedge fb_pfd) fb_n <= fb_n + 16'h0001;

    // ----------------
    // Helper tasks
    // ----------------
    task automatic chk(input logic [15:0] got, input logic [15:0] exp);
        num_checks++;
        if (got !== exp) begin
            fails++;
            $display("wrong value at %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    task automatic wr(input logic [3:0] a, input logic [7:0] d);
        @(posedge clock);
        reg_addr  <= a;
        reg_wdata <= d;
        reg_write <= 1'h1;
        @(posedge clock);
        reg_write <= 1'h0;
    endtask
    task automatic rd(input logic [3:0] a, output logic [7:0] d);
        @(posedge clock);
        reg_addr <= a;
        reg_read <= 1'h1;
        @(posedge clock);
        reg_read <= 1'h0;
        #1;
        d = reg_rdata;
    endtask
    task automatic mres_pulse;
        @(posedge clock);
        master_reset_n <= 1'h0;
        repeat (6) @(posedge clock);
        #1;
        chk({14'h0, primary_out, secondary_out}, 16'h0000);
        @(posedge clock);
        master_reset_n <= 1'h1;
        repeat (8) @(posedge clock);
    endtask
    task automatic meas(output logic [15:0] p, output logic [15:0] s);
        logic [15:0] p0;
        logic [15:0] s0;
        repeat (50) @(posedge clock);
        p0 = prim_cnt;
        s0 = sec_cnt;
        repeat (400) @(posedge clock);
        p = prim_cnt - p0;
        s = sec_cnt - s0;
    endtask
    task automatic settle;
        repeat (3) @(posedge clock);
        #1;
    endtask
    task automatic wrap_up;
        $display("checks %0d mismatches %0d", num_checks, fails);
        if (fails == 0 && num_checks > 0) begin
            $display("Run complete: PASS");
        end else begin
            $display("Run complete: FAIL");
        end
        $finish;
    endtask

    initial begin
        clock = 1'h0;
        forever #4 clock = ~clock;
    end
    initial begin
        repeat (30000) @(posedge clock);
        fails++;
        wrap_up();
    end

    // ----------------
    // Main sequence
    // ----------------
    initial begin
        {fails, num_checks} = '0;
        {reset, pll_select, ref_select, pfd_match, output_halt_a_n, output_halt_b_n} = 6'h3F;
        {master_reset_n, test_enable, config_source_select, reg_write, reg_read} = 5'h00;
        feedback_pins = synoc_pkg::FB_RST;
        output_divider = synoc_pkg::OD_RST;
        secondary_ratio = synoc_pkg::SR_RST;
        predivider_pin = synoc_pkg::PRE_RST;
        reg_addr = 4'h0;
        reg_wdata = 8'h00;
        {ref_n, fb_n} = 32'h0;
        repeat (5) @(posedge clock);
        reset <= 1'h0;
        @(posedge clock);
        #1;
        chk({6'h00, reg_rdata, irq, lock_out}, 16'h0000);
        @(posedge clock);
        master_reset_n <= 1'h1;
        foreach (ROWS[i]) begin
            @(posedge clock);
            pll_select <= ROWS[i].pll;
            output_divider <= ROWS[i].od;
            secondary_ratio <= ROWS[i].sr;
            mres_pulse();
            meas(dp, ds);
            ex = ROWS[i].half ? dp >> 1 : dp;
            chk({15'h0, dp == 16'h0}, 16'h0000);
            chk((ds + 16'h1 >= ex && ds <= ex + 16'h1) ? ex : ds, ex);
        end
        @(posedge clock);
        {pll_select, output_divider, secondary_ratio} <= 5'h00;
        meas(a0, ds);
        ref_select <= 1'h0;
        meas(dp, ds);
        chk({15'h0, a0 > dp}, 16'h0001);
        ref_select <= 1'h1;
        repeat (50) @(posedge clock);
        {ex, a0} = {ref_n, fb_n};
        repeat (400) @(posedge clock);
        ds = ref_n - ex;
        dp = fb_n - a0;
        chk((ds >= 16'h0013 && ds <= 16'h0015) ? 16'h0014 : ds, 16'h0014);
        chk({15'h0, dp == 16'h0000 || dp > 16'h0002}, 16'h0000);
        chk({15'h0, lock_out ^ ref_pfd}, 16'h0000);
        for (int k = 0; k < 2; k++) begin
            @(posedge clock);
            {output_halt_a_n, output_halt_b_n} <= k ? 2'h2 : 2'h1;
            repeat (200) @(posedge clock);
            meas(dp, ds);
            chk(k ? ds : dp, 16'h0000);
            chk({15'h0, (k ? dp : ds) == 16'h0}, 16'h0000);
        end
        {output_halt_a_n, output_halt_b_n, pll_select} <= 3'h7;
        feedback_pins <= 10'h2A7;
        {output_divider, secondary_ratio, predivider_pin} <= 5'h06;
        config_source_select <= 1'h1;
        mres_pulse();
        wr(synoc_pkg::REG_CMD, {4'h0, synoc_pkg::CMD_GET});
        rd(synoc_pkg::REG_CFG_LO, rd_v);
        chk({8'h00, rd_v}, 16'h00A7);
        rd(synoc_pkg::REG_CFG_HI, rd_v);
        chk({9'h000, rd_v[7:1]}, 16'h0046);
        wr(synoc_pkg::REG_CFG_LO, 8'h3C);
        wr(synoc_pkg::REG_CMD, {4'h0, synoc_pkg::CMD_LOAD});
        feedback_pins <= 10'h155;
        wr(synoc_pkg::REG_CMD, {4'h0, synoc_pkg::CMD_INC});
        wr(synoc_pkg::REG_CMD, {4'h0, synoc_pkg::CMD_INC});
        wr(synoc_pkg::REG_CMD, {4'h0, synoc_pkg::CMD_DEC});
        wr(synoc_pkg::REG_CMD, {4'h0, synoc_pkg::CMD_GET});
        rd(synoc_pkg::REG_CFG_LO, rd_v);
        chk({8'h00, rd_v}, 16'h003D);
        @(posedge clock);
        config_source_select <= 1'h0;
        rd(synoc_pkg::REG_ID, rd_v);
        chk({8'h00, rd_v}, {8'h00, synoc_pkg::ID_VALUE});
        wr(4'h5, 8'hFF);
        rd(4'h5, rd_v);
        chk({8'h00, rd_v}, 16'h0000);
        wr(synoc_pkg::REG_MASK, 8'h00);
        mres_pulse();
        wr(synoc_pkg::REG_MASK, 8'h04);
        settle();
        chk({15'h0, irq}, 16'h0001);
        wr(synoc_pkg::REG_STATUS, 8'h04);
        settle();
        chk({15'h0, irq}, 16'h0000);
        @(posedge clock);
        pfd_match <= 1'h0;
        settle();
        settle();
        chk({15'h0, lock_out}, 16'h0000);
        wr(synoc_pkg::REG_STATUS, 8'h07);
        wr(synoc_pkg::REG_MASK, 8'h01);
        pfd_match <= 1'h1;
        repeat (LOCK + 8) @(posedge clock);
        #1;
        chk({14'h0, lock_out, irq}, 16'h0003);
        wr(synoc_pkg::REG_STATUS, 8'h01);
        settle();
        chk({15'h0, irq}, 16'h0000);
        for (int k = 1; k >= 0; k--) begin
            @(posedge clock);
            test_enable <= k[0];
            settle();
            chk({15'h0, test_mode}, k[15:0]);
        end
        wrap_up();
    end
endmodule
